// ===== src/qrc_pkg.sv
package qrc_pkg;

  // Register map
  localparam logic [19:0] CLK_CFG_OFS   = 20'h3_0B03;
  localparam logic [19:0] PLL_CFG_OFS   = 20'h3_0B04;
  localparam logic [19:0] ALARM_OFS     = 20'h3_0B05;
  localparam logic [19:0] THRESH_OFS    = 20'h3_0B06;

  // Field positions
  localparam int BURST_BIT  = 0;
  localparam int SRC_LO     = 2;
  localparam int OCK_BIT    = 7;
  localparam int PLL_N_LO   = 1;
  localparam int PLL_M_LO   = 5;
  localparam int LEN_LO     = 18;

  // Reset values
  localparam logic [7:0] CLK_CFG_RST = 8'h00;
  localparam logic [7:0] PLL_CFG_RST = 8'h00;
  localparam logic [3:0] THRESH_RST  = 4'h0;

  // Widths and depths
  localparam int ADDR_W      = 18;
  localparam int LEN_W       = 6;
  localparam int CMD_W       = 32;
  localparam int BEAT_W      = 36;
  localparam int WORD_W      = 72;
  localparam int CMD_DEPTH   = 4;
  localparam int DATA_DEPTH  = 64;
  localparam int STAGE_DEPTH = 8;

  // Timing: memory clock edges from read address to returned data
  localparam int RD_LAT = 2;

  // Cycles a burst holds the one-beat-per-clock data bus after its strobe
  localparam logic [1:0] GAP_TWO  = 2'h1;
  localparam logic [1:0] GAP_FOUR = 2'h3;

  // Alarm bit positions
  localparam int AL_WR_LEN  = 0;
  localparam int AL_WR_ID   = 1;
  localparam int AL_WD_OVR  = 2;
  localparam int AL_WD_UDR  = 3;
  localparam int AL_RD_OVR  = 4;
  localparam int AL_RD_UDR  = 5;
  localparam int AL_CMD_OVR = 6;
  localparam int AL_W       = 7;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ISSUE  = 2'b01,
    ST_SECOND = 2'b10
  } qrc_seq_t;

  typedef struct packed {
    logic [LEN_W-1:0]  len;
    logic [ADDR_W-1:0] addr;
  } qrc_cmd_t;

  typedef struct packed {
    logic [1:0] source_sel;
    logic       mode_sel;
    logic [2:0] pll_n;
    logic [2:0] pll_m;
  } qrc_clk_t;

endpackage : qrc_pkg

// ===== src/qrc_read_ctrl.sv
`timescale 1ns/1ns
// What this block does
// R1 - Pop each pending instruction, split address and length, load the address counter.
// R2 - Issue two- or four-word read bursts per config; tell write side when address is taken.
// R3 - Read address drives 17 active lines in two-word mode, 18 in four-word mode.
// R4 - Pair the two 36-bit DDR beats into one 72-bit word.
// R5 - Latch beats with the echo clock pair, then retime before buffering.
// R6 - Read data buffer holds 64 words of 72 bits, drained by fabric reads.
// R7 - Instruction buffer holds four 32-bit instructions of length and address.
// R8 - Full flag is high while one slot or none is free; one more write allowed when it rises.
// R9 - Fabric starts reading data only after the empty flag drops.
// R10 - Fabric counts words read and checks them against the instruction length.
// R11 - Data returns strictly in instruction order.
// R12 - Empty flag threshold comes from a 4-bit software field.
// R13 - Empty flag stays high until fetched data is really in the buffer.
// R14 - Write instruction reaches the memory write strobe about two cycles after entry.
// R15 - Read instructions have the same two-cycle latency to memory.
// R16 - Alarm bit when write data amount differs from instruction length.
// R17 - Coherency alarm bit when write data tag differs from instruction tag.
// R18 - Alarm bits for overrun and underrun of write and read data buffers.
// R19 - Fabric write clock times write buffers, read clock times read buffers.
// R20 - Two-bit field picks main clock: controller, first link, second link, fabric.
// R21 - Mode bit picks PLL (N+1)/(2(M+1)) or divide by two.
// R22 - PLL N from bits 1 to 3, M from bits 5 to 7 of second register.
// R23 - Read data expected on the second memory clock edge after the read address.
// R24 - Alarm bits stay set until software clears them; each also pulses an event.
// R25 - Flags crossing clock domains are synchronized.

module qrc_fifo #(
  parameter int W = 72,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Fill side
  input  wire logic                   in_valid_i,
  input  wire logic [W-1:0]           in_data_i,
  output logic                        in_ready_o,
  // Drain side
  output logic                        out_valid_o,
  output logic [W-1:0]                out_data_o,
  input  wire logic                   out_ready_i,
  // Fill level
  output logic [$clog2(D+1)-1:0]      count_o
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } fifo_st_t;

  fifo_st_t s;
  fifo_st_t next_s;
  logic     push;
  logic     pop;

  assign in_ready_o  = (s.cnt != CW'(D));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];
  assign count_o     = s.cnt;

  always_comb begin
    next_s = s;
    push   = in_valid_i && in_ready_o;
    pop    = out_valid_o && out_ready_i;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = (s.wp == PW'(D-1)) ? '0 : s.wp + PW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == PW'(D-1)) ? '0 : s.rp + PW'(1);
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : qrc_fifo

module qrc_read_ctrl
  import qrc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Register port
  input  wire logic [19:0]          reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_we_i,
  input  wire logic                 reg_re_i,
  output logic [7:0]                reg_rdata_o,
  // Fabric read instructions
  input  wire logic                 cmd_we_i,
  input  wire logic [CMD_W-1:0]     cmd_i,
  output logic                      read_cmd_buffer_full_o,
  // Fabric read data
  input  wire logic                 rd_re_i,
  output logic [WORD_W-1:0]         rd_data_o,
  output logic                      read_data_buffer_empty_o,
  // QDR-II SRAM read port
  output logic [ADDR_W-1:0]         sram_addr_o,
  output logic                      sram_rd_n_o,
  input  wire logic [BEAT_W-1:0]    sram_q_i,
  input  wire logic                 sram_cq_i,
  input  wire logic                 sram_cqn_i,
  // Write sequencer handshake and its error events
  input  wire logic                 wr_addr_req_i,
  output logic                      rd_addr_busy_o,
  input  wire logic                 wr_len_err_i,
  input  wire logic                 wr_id_err_i,
  input  wire logic                 wr_data_ovr_i,
  input  wire logic                 wr_data_udr_i,
  // Clock selection
  output logic [1:0]                main_clock_source_sel_o,
  output logic                      output_clock_mode_sel_o,
  output logic [2:0]                pll_n_o,
  output logic [2:0]                pll_m_o,
  // Alarm event
  output logic                      alarm_event_o
);
  localparam int CCW = $clog2(CMD_DEPTH+1);
  localparam int DCW = $clog2(DATA_DEPTH+1);

  typedef struct packed {
    logic [7:0]          clk_cfg;
    logic [7:0]          pll_cfg;
    logic [3:0]          thresh;
    logic [AL_W-1:0]     alarms;
    logic [7:0]          reg_rdata;
    qrc_seq_t            seq;
    logic [ADDR_W-1:0]   addr;
    logic [LEN_W:0]      left;
    logic [DCW-1:0]      credit;
    logic [RD_LAT:0]     keep_sr;
    logic                last_wr;
    logic [1:0]          gap;
    logic                rd_n;
    logic                busy;
    logic [ADDR_W-1:0]   sram_addr;
    logic [BEAT_W-1:0]   beat_lo;
    logic [WORD_W-1:0]   word;
    logic                word_vld;
    logic [WORD_W-1:0]   rd_data;
    logic                empty;
    logic                full;
    logic                alarm_evt;
    qrc_clk_t            clk_out;
  } top_st_t;

  top_st_t             s;
  top_st_t             next_s;

  logic                cmd_ready;
  logic                cmd_valid;
  logic [CMD_W-1:0]    cmd_data;
  logic [CCW-1:0]      cmd_cnt;
  logic                stage_ready;
  logic                stage_valid;
  logic [WORD_W-1:0]   stage_data;
  logic                data_ready;
  logic                data_valid;
  logic [WORD_W-1:0]   data_out;
  logic [DCW-1:0]      data_cnt;

  logic                cmd_push;
  logic                cmd_pop;
  logic                rd_pop;
  logic                stage_to_data;
  logic                four;
  logic                go;
  logic                keep_now;
  logic [DCW-1:0]      need;
  logic [DCW-1:0]      taken;
  logic [AL_W-1:0]     al_set;
  logic [AL_W-1:0]     al_clr;
  logic [CCW-1:0]      cmd_cnt_next;
  logic [DCW-1:0]      data_cnt_next;
  qrc_cmd_t            cmd;

  // Instruction buffer
  qrc_fifo #(.W(CMD_W), .D(CMD_DEPTH)) u_cmd_buf (          // [R7] [R19]
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (cmd_we_i),
    .in_data_i   (cmd_i),
    .in_ready_o  (cmd_ready),
    .out_valid_o (cmd_valid),
    .out_data_o  (cmd_data),
    .out_ready_i (cmd_pop),
    .count_o     (cmd_cnt)
  );

  // Staging between capture and data buffer; its ready stalls issue
  qrc_fifo #(.W(WORD_W), .D(STAGE_DEPTH)) u_stage_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (s.word_vld),
    .in_data_i   (s.word),
    .in_ready_o  (stage_ready),
    .out_valid_o (stage_valid),
    .out_data_o  (stage_data),
    .out_ready_i (data_ready),
    .count_o     ()
  );

  // Read data buffer
  qrc_fifo #(.W(WORD_W), .D(DATA_DEPTH)) u_read_data_buffer (  // [R6] [R19]
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (stage_valid),
    .in_data_i   (stage_data),
    .in_ready_o  (data_ready),
    .out_valid_o (data_valid),
    .out_data_o  (data_out),
    .out_ready_i (rd_pop),
    .count_o     (data_cnt)
  );

  always_comb begin
    next_s        = s;
    cmd           = qrc_cmd_t'(cmd_data[LEN_LO+LEN_W-1:0]);    // [R1]
    cmd_push      = cmd_we_i && cmd_ready;
    cmd_pop       = (s.seq == ST_IDLE) && cmd_valid;
    rd_pop        = rd_re_i && data_valid;
    stage_to_data = stage_valid && data_ready;
    four          = s.clk_cfg[BURST_BIT];
    need          = four ? DCW'(2) : DCW'(1);
    // Alternate with writes so neither side starves the shared address bus
    go            = (s.credit >= need) && stage_ready && (!wr_addr_req_i || s.last_wr);  // [R2]
    keep_now      = 1'b0;
    taken         = '0;
    next_s.rd_n   = 1'b1;

    case (s.seq)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_s.addr = cmd.addr;                                  // [R1]
          next_s.left = (cmd.len == '0) ? (LEN_W+1)'(DATA_DEPTH) : {1'b0, cmd.len};
          next_s.seq  = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (go) begin
          next_s.rd_n      = 1'b0;                                 // [R14] [R15] [R2]
          next_s.sram_addr = four ? s.addr : {1'b0, s.addr[ADDR_W-2:0]};  // [R3]
          next_s.addr      = s.addr + ADDR_W'(1);
          next_s.left      = s.left - (LEN_W+1)'(1);
          next_s.last_wr   = 1'b0;
          keep_now         = 1'b1;
          taken            = DCW'(1);
          next_s.gap       = four ? GAP_FOUR : GAP_TWO;
          next_s.seq       = ST_SECOND;
        end else if (wr_addr_req_i) begin
          next_s.last_wr = 1'b1;
        end
      end
      ST_SECOND: begin
        // Each beat takes a clock, so the next burst waits for the data bus
        next_s.gap = s.gap - 2'h1;
        // Odd length in four-word mode: the surplus line is dropped here
        if (four && s.gap == GAP_FOUR - 2'h1 && s.left != '0) begin
          keep_now    = 1'b1;
          taken       = DCW'(1);
          next_s.left = s.left - (LEN_W+1)'(1);
        end
        if (s.gap == 2'h1) begin
          next_s.seq = (s.left == '0) ? ST_IDLE : ST_ISSUE;
        end
      end
      default: begin
        next_s.seq = ST_IDLE;
      end
    endcase

    // Returned-line markers travel in issue order, so data keeps order
    next_s.keep_sr = {s.keep_sr[RD_LAT-1:0], keep_now};           // [R11] [R23]
    next_s.credit  = s.credit - taken + DCW'(rd_pop);
    next_s.busy    = !next_s.rd_n;

    // Echo-clock latches, then one retiming stage
    if (sram_cq_i) begin
      next_s.beat_lo = sram_q_i;                                   // [R5]
    end
    if (sram_cqn_i) begin
      next_s.word = {s.beat_lo, sram_q_i};                         // [R4] [R5]
    end
    next_s.word_vld = s.keep_sr[RD_LAT];

    // Fabric read port
    if (rd_pop) begin
      next_s.rd_data = data_out;
    end
    cmd_cnt_next  = cmd_cnt + CCW'(cmd_push) - CCW'(cmd_pop);
    data_cnt_next = data_cnt + DCW'(stage_to_data) - DCW'(rd_pop);
    next_s.full   = (cmd_cnt_next >= CCW'(CMD_DEPTH-1));          // [R8] [R25]
    // Flag follows buffer contents only, never issued-but-unreturned reads
    next_s.empty  = (data_cnt_next <= DCW'(s.thresh));            // [R12] [R13]

    // Alarms
    al_set             = '0;
    al_set[AL_WR_LEN]  = wr_len_err_i;                             // [R16]
    al_set[AL_WR_ID]   = wr_id_err_i;                              // [R17]
    al_set[AL_WD_OVR]  = wr_data_ovr_i;                            // [R18]
    al_set[AL_WD_UDR]  = wr_data_udr_i;                            // [R18]
    al_set[AL_RD_OVR]  = s.word_vld && !stage_ready;               // [R18]
    al_set[AL_RD_UDR]  = rd_re_i && !data_valid;                   // [R18]
    al_set[AL_CMD_OVR] = cmd_we_i && !cmd_ready;
    al_clr             = '0;

    // Register port
    if (reg_we_i) begin
      if (reg_addr_i == CLK_CFG_OFS) begin
        next_s.clk_cfg = reg_wdata_i;
      end else if (reg_addr_i == PLL_CFG_OFS) begin
        next_s.pll_cfg = reg_wdata_i;
      end else if (reg_addr_i == ALARM_OFS) begin
        al_clr = reg_wdata_i[AL_W-1:0];
      end else if (reg_addr_i == THRESH_OFS) begin
        next_s.thresh = reg_wdata_i[3:0];
      end
    end
    // Set wins over a same-cycle clear
    next_s.alarms    = (s.alarms & ~al_clr) | al_set;              // [R24]
    next_s.alarm_evt = |al_set;                                    // [R24]

    if (reg_re_i) begin
      if (reg_addr_i == CLK_CFG_OFS) begin
        next_s.reg_rdata = s.clk_cfg;
      end else if (reg_addr_i == PLL_CFG_OFS) begin
        next_s.reg_rdata = s.pll_cfg;
      end else if (reg_addr_i == ALARM_OFS) begin
        next_s.reg_rdata = {1'b0, s.alarms};
      end else if (reg_addr_i == THRESH_OFS) begin
        next_s.reg_rdata = {4'h0, s.thresh};
      end else begin
        next_s.reg_rdata = 8'h00;
      end
    end

    next_s.clk_out.source_sel = s.clk_cfg[SRC_LO+1:SRC_LO];        // [R20]
    next_s.clk_out.mode_sel   = s.clk_cfg[OCK_BIT];                // [R21]
    next_s.clk_out.pll_n      = s.pll_cfg[PLL_N_LO+2:PLL_N_LO];    // [R22]
    next_s.clk_out.pll_m      = s.pll_cfg[PLL_M_LO+2:PLL_M_LO];    // [R22]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s           <= '0;
      s.clk_cfg   <= CLK_CFG_RST;
      s.pll_cfg   <= PLL_CFG_RST;
      s.thresh    <= THRESH_RST;
      s.seq       <= ST_IDLE;
      s.credit    <= DCW'(DATA_DEPTH);
      s.rd_n      <= 1'b1;
      s.empty     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o              = s.reg_rdata;
  assign read_cmd_buffer_full_o   = s.full;
  assign rd_data_o                = s.rd_data;
  assign read_data_buffer_empty_o = s.empty;
  assign sram_addr_o              = s.sram_addr;
  assign sram_rd_n_o              = s.rd_n;
  assign rd_addr_busy_o           = s.busy;
  assign main_clock_source_sel_o  = s.clk_out.source_sel;
  assign output_clock_mode_sel_o  = s.clk_out.mode_sel;
  assign pll_n_o                  = s.clk_out.pll_n;
  assign pll_m_o                  = s.clk_out.pll_m;
  assign alarm_event_o            = s.alarm_evt;

endmodule : qrc_read_ctrl

// ===== tb/qrc_read_ctrl_props.sv
`timescale 1ns/1ns
module qrc_read_ctrl_props
  import qrc_pkg::*;
(
  // Clock, reset and registers
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [19:0]       reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_we_i,
  // Fabric side
  input wire logic              cmd_we_i,
  input wire logic              read_cmd_buffer_full_o,
  input wire logic              read_data_buffer_empty_o,
  // Memory side
  input wire logic [ADDR_W-1:0] sram_addr_o,
  input wire logic              sram_rd_n_o,
  input wire logic              sram_cqn_i,
  input wire logic              rd_addr_busy_o,
  // Events and clock selection
  input wire logic              wr_len_err_i,
  input wire logic              wr_id_err_i,
  input wire logic              wr_data_ovr_i,
  input wire logic              wr_data_udr_i,
  input wire logic [1:0]        main_clock_source_sel_o,
  input wire logic              output_clock_mode_sel_o,
  input wire logic [2:0]        pll_n_o,
  input wire logic [2:0]        pll_m_o,
  input wire logic              alarm_event_o
);
  logic four;
  logic cqn_seen;

  // Mode is tracked from writes only, so mode changes during traffic are not judged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      four     <= 1'b0;
      cqn_seen <= 1'b0;
    end else begin
      if (reg_we_i && reg_addr_i == CLK_CFG_OFS) begin
        four <= reg_wdata_i[BURST_BIT];
      end
      if (sram_cqn_i) begin
        cqn_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_values_a: assert property ($fell(rst_i) |-> sram_rd_n_o && read_data_buffer_empty_o && !read_cmd_buffer_full_o)
    else $error("outputs not at reset level");
  strobe_single_a: assert property ($fell(sram_rd_n_o) |=> sram_rd_n_o)
    else $error("read strobe longer than one cycle");
  addr_owned_a: assert property (!sram_rd_n_o |-> rd_addr_busy_o)
    else $error("strobe without address ownership");
  addr_narrow_a: assert property (!sram_rd_n_o && !four |-> !sram_addr_o[17])
    else $error("top address line active in two-word mode");
  full_cause_a: assert property ($rose(read_cmd_buffer_full_o) |-> $past(cmd_we_i) || $past(cmd_we_i, 2))
    else $error("full flag rose without an instruction write");
  empty_data_a: assert property ($fell(read_data_buffer_empty_o) |-> cqn_seen)
    else $error("empty flag dropped before any data returned");
  clock_sel_a: assert property (reg_we_i && reg_addr_i == CLK_CFG_OFS |-> ##2
      main_clock_source_sel_o == $past(reg_wdata_i[3:2], 2) && output_clock_mode_sel_o == $past(reg_wdata_i[7], 2))
    else $error("clock selection does not follow register");
  pll_fields_a: assert property (reg_we_i && reg_addr_i == PLL_CFG_OFS |-> ##2
      pll_n_o == $past(reg_wdata_i[3:1], 2) && pll_m_o == $past(reg_wdata_i[7:5], 2))
    else $error("pll fields do not follow register");
  alarm_event_a: assert property (wr_len_err_i || wr_id_err_i || wr_data_ovr_i || wr_data_udr_i |-> ##[1:2] alarm_event_o)
    else $error("alarm event missing");
endmodule : qrc_read_ctrl_props

bind qrc_read_ctrl qrc_read_ctrl_props i_qrc_read_ctrl_props (.*);

// ===== tb/qrc_sram_mdl.sv
`timescale 1ns/1ns
package qrc_mdl_pkg;
  function automatic logic [71:0] mdl_word(input logic [17:0] a);
    return {a, 18'h2_5A3C, ~a, 18'h1_C3A5};
  endfunction : mdl_word
endpackage : qrc_mdl_pkg

module qrc_sram_mdl
  import qrc_pkg::*, qrc_mdl_pkg::*;
(
  // Controller side
  input  wire logic              clk_i,
  input  wire logic [ADDR_W-1:0] sram_addr_i,
  input  wire logic              sram_rd_n_i,
  // Returned beats
  output logic [BEAT_W-1:0]      sram_q_o,
  output logic                   sram_cq_o,
  output logic                   sram_cqn_o
);
  logic [BEAT_W-1:0] beat_q [4];
  logic [1:0]        kind_q [4];
  logic [71:0]       word;
  int                n = 0;

  initial begin
    sram_q_o   = '0;
    sram_cq_o  = 1'b0;
    sram_cqn_o = 1'b0;
    foreach (kind_q[i]) kind_q[i] = 2'h0;
  end

  // Beats move on the falling edge so they are settled at the capturing edge
  always @(negedge clk_i) begin
    if (sram_rd_n_i === 1'b0) begin
      word = mdl_word(sram_addr_i);
      beat_q[n % 4]       = word[71:36];
      kind_q[n % 4]       = 2'h1;
      beat_q[(n + 1) % 4] = word[35:0];
      kind_q[(n + 1) % 4] = 2'h2;
    end
    // Released bus toggles so stale data is never mistaken for a beat
    sram_q_o      = (kind_q[n % 4] != 2'h0) ? beat_q[n % 4] : ~sram_q_o;
    sram_cq_o     = kind_q[n % 4] == 2'h1;
    sram_cqn_o    = kind_q[n % 4] == 2'h2;
    kind_q[n % 4] = 2'h0;
    n++;
  end
endmodule : qrc_sram_mdl

// ===== tb/qdr_sram_read_path_ctrl_test.sv
`timescale 1ns/1ns
module qdr_sram_read_path_ctrl_test;
  import qrc_pkg::*;
  import qrc_mdl_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [19:0]       reg_addr_i = '0;
  logic [7:0]        reg_wdata_i = '0;
  logic              reg_we_i = 1'b0;
  logic              reg_re_i = 1'b0;
  logic [7:0]        reg_rdata_o;
  logic              cmd_we_i = 1'b0;
  logic [CMD_W-1:0]  cmd_i = '0;
  logic              read_cmd_buffer_full_o;
  logic              rd_re_i = 1'b0;
  logic [WORD_W-1:0] rd_data_o;
  logic              read_data_buffer_empty_o;
  logic [ADDR_W-1:0] sram_addr_o;
  logic              sram_rd_n_o;
  logic [BEAT_W-1:0] sram_q;
  logic              sram_cq;
  logic              sram_cqn;
  logic              wr_req = 1'b0;
  logic              rd_addr_busy_o;
  logic [3:0]        wr_err = '0;
  logic [1:0]        main_clock_source_sel_o;
  logic              output_clock_mode_sel_o;
  logic [2:0]        pll_n_o;
  logic [2:0]        pll_m_o;
  logic              alarm_event_o;
  logic [ADDR_W-1:0] last_addr;
  logic [71:0]       exp_q [$];
  int                fails = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                strobes = 0;

  qrc_read_ctrl i_qrc_read_ctrl (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .cmd_we_i(cmd_we_i), .cmd_i(cmd_i),
    .read_cmd_buffer_full_o(read_cmd_buffer_full_o), .rd_re_i(rd_re_i), .rd_data_o(rd_data_o),
    .read_data_buffer_empty_o(read_data_buffer_empty_o), .sram_addr_o(sram_addr_o), .sram_rd_n_o(sram_rd_n_o),
    .sram_q_i(sram_q), .sram_cq_i(sram_cq), .sram_cqn_i(sram_cqn), .wr_addr_req_i(wr_req),
    .rd_addr_busy_o(rd_addr_busy_o), .wr_len_err_i(wr_err[0]), .wr_id_err_i(wr_err[1]), .wr_data_ovr_i(wr_err[2]),
    .wr_data_udr_i(wr_err[3]), .main_clock_source_sel_o(main_clock_source_sel_o),
    .output_clock_mode_sel_o(output_clock_mode_sel_o), .pll_n_o(pll_n_o), .pll_m_o(pll_m_o),
    .alarm_event_o(alarm_event_o));

  qrc_sram_mdl i_qrc_sram_mdl (.clk_i(clk_i), .sram_addr_i(sram_addr_o), .sram_rd_n_i(sram_rd_n_o),
    .sram_q_o(sram_q), .sram_cq_o(sram_cq), .sram_cqn_o(sram_cqn));

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (!sram_rd_n_o && !rst_i) begin
      strobes++;
      last_addr = sram_addr_o;
    end
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_we_i    = 1'b1;
    @(negedge clk_i);
    reg_we_i = 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [19:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_re_i   = 1'b1;
    @(negedge clk_i);
    reg_re_i = 1'b0;
    chk("register", {64'h0, e}, {64'h0, reg_rdata_o});
  endtask : reg_chk

  // Two-word bursts only: one line per burst, top address line dropped
  task automatic issue(input logic [17:0] a, input logic [5:0] len, input bit keep);
    logic [17:0] b;
    @(negedge clk_i);
    cmd_i    = {8'h00, len, a};
    cmd_we_i = 1'b1;
    @(negedge clk_i);
    cmd_we_i = 1'b0;
    for (int k = 0; k < ((len == 0) ? 64 : len) && keep; k++) begin
      b     = a + 18'(k);
      b[17] = 1'b0;
      exp_q.push_back(mdl_word(b));
    end
  endtask : issue

  task automatic settle(input int n);
    for (int g = 0; g < 500 && strobes < n; g++) @(negedge clk_i);
    repeat (10) @(negedge clk_i);
  endtask : settle

  task automatic drain(input int n);
    int k;
    k = 0;
    for (int g = 0; g < 3000 && k < n; g++) begin
      @(negedge clk_i);
      if (rd_re_i) begin
        chk("read word", exp_q.pop_front(), rd_data_o);
        k++;
      end
      rd_re_i = (k < n) && !read_data_buffer_empty_o;
    end
    chk("words read", 72'(n), 72'(k));
  endtask : drain

  task automatic t_clock;
    logic [7:0] d;
    reg_chk(CLK_CFG_OFS, CLK_CFG_RST);
    reg_chk(PLL_CFG_OFS, PLL_CFG_RST);
    reg_chk(20'h3_0B07, 8'h00);
    for (int s = 0; s < 4; s++) begin
      d = {s[0], 3'h0, s[1:0], 2'h0};
      reg_wr(CLK_CFG_OFS, d);
      @(negedge clk_i);
      chk("source select", 72'(s[1:0]), 72'(main_clock_source_sel_o));
      chk("output mode", 72'(s[0]), 72'(output_clock_mode_sel_o));
      reg_chk(CLK_CFG_OFS, d);
    end
    reg_wr(PLL_CFG_OFS, 8'hA6);
    @(negedge clk_i);
    chk("pll n", 72'h3, 72'(pll_n_o));
    chk("pll m", 72'h5, 72'(pll_m_o));
  endtask : t_clock

  // Full data buffer stalls the sequencer so instructions pile up
  task automatic t_fill;
    int k;
    issue(18'h0_0100, 6'h00, 1'b1);
    settle(64);
    for (k = 0; k < 6; k++) begin
      issue(18'h3_0200 + 18'(16 * k), 6'h01, k < 5);
      repeat (3) @(negedge clk_i);
      chk("instruction full", 72'(k >= 3), 72'(read_cmd_buffer_full_o));
    end
    reg_chk(ALARM_OFS, 8'h40);
    reg_wr(ALARM_OFS, 8'h40);
    reg_chk(ALARM_OFS, 8'h00);
    drain(68);
    issue(18'h0_0040, 6'h01, 1'b1);
    k = 0;
    while (k < 8 && sram_rd_n_o === 1'b1) begin
      @(negedge clk_i);
      k++;
    end
    chk("strobe latency", 72'h2, 72'(k));
    drain(2);
  endtask : t_fill

  task automatic t_thresh;
    int s0;
    reg_wr(THRESH_OFS, 8'h02);
    reg_chk(THRESH_OFS, 8'h02);
    s0 = strobes;
    issue(18'h0_0300, 6'h02, 1'b1);
    settle(s0 + 2);
    chk("empty at level", 72'h1, 72'(read_data_buffer_empty_o));
    issue(18'h0_0310, 6'h01, 1'b1);
    settle(s0 + 3);
    chk("empty above level", 72'h0, 72'(read_data_buffer_empty_o));
    reg_wr(THRESH_OFS, 8'h00);
    drain(3);
  endtask : t_thresh

  task automatic t_alarm;
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      wr_err = 4'(1 << i);
      @(negedge clk_i);
      wr_err = 4'h0;
      chk("alarm event", 72'h1, 72'(alarm_event_o));
      acc[i] = 1'b1;
      reg_chk(ALARM_OFS, acc);
    end
    @(negedge clk_i);
    rd_re_i = 1'b1;
    @(negedge clk_i);
    rd_re_i = 1'b0;
    reg_chk(ALARM_OFS, 8'h2F);
    reg_wr(ALARM_OFS, 8'h2F);
    reg_chk(ALARM_OFS, 8'h00);
  endtask : t_alarm

  // Four-word data is not judged; the reset afterwards discards it
  task automatic t_four;
    int s0;
    reg_wr(CLK_CFG_OFS, 8'h01);
    wr_req = 1'b1;
    s0     = strobes;
    issue(18'h2_0010, 6'h02, 1'b0);
    settle(s0 + 1);
    chk("bursts for two lines", 72'(s0 + 1), 72'(strobes));
    chk("four-word address", 72'h2_0010, 72'(last_addr));
    wr_req = 1'b0;
    rst_i  = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk("empty after reset", 72'h1, 72'(read_data_buffer_empty_o));
    reg_chk(CLK_CFG_OFS, CLK_CFG_RST);
  endtask : t_four

  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    t_clock();
    t_fill();
    t_thresh();
    t_alarm();
    t_four();
    wrap_up();
  end
endmodule : qdr_sram_read_path_ctrl_test
